// File: coil_cfg_pkg.sv
package coil_cfg_pkg;

  // Parameter access port geometry
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned IDX_W    = 4;
  localparam int unsigned NUM_SVC  = 3;
  localparam int unsigned NUM_REGS = 13;

  // Parameter indices on the access port
  localparam logic [3:0] IDX_SUPPLY_MASK  = 4'h0;
  localparam logic [3:0] IDX_EDGE_COUNT   = 4'h1;
  localparam logic [3:0] IDX_PERIOD       = 4'h2;
  localparam logic [3:0] IDX_ANGLE        = 4'h3;
  localparam logic [3:0] IDX_MANUAL_TRIG  = 4'h4;
  localparam logic [3:0] IDX_STARTUP_EN   = 4'h5;
  localparam logic [3:0] IDX_RUN_COUNT    = 4'h6;
  localparam logic [3:0] IDX_BROKEN_SVC1  = 4'h7;
  localparam logic [3:0] IDX_LIMP_SVC1    = 4'hA;

  // Field widths
  localparam int unsigned EDGE_W   = 7;
  localparam int unsigned PERIOD_W = 15;
  localparam int unsigned ANGLE_W  = 13;
  localparam int unsigned COUNT_W  = 8;
  localparam int unsigned BROKEN_W = 4;
  localparam int unsigned LIMP_W   = 2;

  // Values after reset
  localparam logic                RST_SUPPLY_MASK = 1'h0;
  localparam logic [EDGE_W-1:0]   RST_EDGE_COUNT  = 7'h0D;
  localparam logic [PERIOD_W-1:0] RST_PERIOD      = 15'h7FFF;
  localparam logic [ANGLE_W-1:0]  RST_ANGLE       = 13'h1C20;
  localparam logic                RST_MANUAL_TRIG = 1'h0;
  localparam logic                RST_STARTUP_EN  = 1'h1;
  localparam logic [COUNT_W-1:0]  RST_RUN_COUNT   = 8'h00;
  localparam logic [BROKEN_W-1:0] RST_BROKEN      = 4'h0;
  localparam logic [LIMP_W-1:0]   RST_LIMP        = 2'h1;

  // Limits, expressed at the width of the write data; the run count limit at the count width
  localparam logic [DATA_W-1:0] MAX_EDGE_COUNT = 16'h0064;
  localparam logic [DATA_W-1:0] MAX_PERIOD     = 16'h7FFF;
  localparam logic [DATA_W-1:0] MAX_ANGLE      = 16'h1C20;
  localparam logic [DATA_W-1:0] MAX_BROKEN     = 16'h000B;
  localparam logic [DATA_W-1:0] MIN_LIMP       = 16'h0001;
  localparam logic [DATA_W-1:0] MAX_LIMP       = 16'h0003;
  localparam logic [COUNT_W-1:0] MAX_RUN_COUNT = 8'hFF;

  // Coil test sequencer states
  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_IDLE = 3'b010,
    ST_RUN  = 3'b100
  } seq_state_t;

endpackage

// File: coil_test_if.sv
`timescale 1ns/10ps
interface coil_test_if;
  import coil_cfg_pkg::*;
  logic               startup_en;
  logic               manual_trig;
  logic               speed_zero;
  logic               coil_done;
  logic               coil_req;
  logic               drive_ok;
  logic               busy;
  logic [COUNT_W-1:0] run_count;

  modport seq (
    input  startup_en, manual_trig, speed_zero, coil_done,
    output coil_req, drive_ok, busy, run_count
  );
  modport bank (
    output startup_en, manual_trig, speed_zero, coil_done,
    input  coil_req, drive_ok, busy, run_count
  );
endinterface

// File: coil_test_seq.sv
`timescale 1ns/10ps
module coil_test_seq (
  // Clock, reset, enable
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Link to the parameter bank
  coil_test_if.seq  ct
);
  import coil_cfg_pkg::*;

  seq_state_t         state_r;
  seq_state_t         state_nxt;
  logic               armed_r;
  logic               req_r;
  logic               drive_ok_r;
  logic [COUNT_W-1:0] count_r;

  // Start conditions; a test is only allowed with the shaft standing still
  wire boot_go   = ct.startup_en & ct.speed_zero;
  wire manual_go = ct.manual_trig & armed_r & ct.speed_zero;
  wire start     = ((state_r == ST_BOOT) & boot_go) | ((state_r == ST_IDLE) & manual_go);
  wire finish    = (state_r == ST_RUN) & ct.coil_done;

  // Next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_BOOT: state_nxt = boot_go ? ST_RUN : ST_IDLE;
      ST_IDLE: state_nxt = manual_go ? ST_RUN : ST_IDLE;
      ST_RUN:  state_nxt = ct.coil_done ? ST_IDLE : ST_RUN;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_BOOT;
      req_r   <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      req_r   <= start | (req_r & ~finish);
    end
  end

  // rearm on zero trigger; a held trigger never repeats the test
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_r <= 1'b1;
    end else if (ce) begin
      armed_r <= ~ct.manual_trig | (armed_r & ~start);
    end
  end

  // normal drive held until startup test ends or is skipped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_ok_r <= 1'b0;
    end else if (ce) begin
      drive_ok_r <= drive_ok_r | finish | ((state_r == ST_BOOT) & ~boot_go);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= RST_RUN_COUNT;
    end else if (ce && start && count_r != MAX_RUN_COUNT) begin
      count_r <= count_r + 8'h01;
    end
  end

  assign ct.coil_req  = req_r;
  assign ct.drive_ok  = drive_ok_r;
  assign ct.busy      = (state_r == ST_RUN);
  assign ct.run_count = count_r;

  sequence boot_skip_s;
    (state_r == ST_BOOT) && ce && !boot_go;
  endsequence

  start_zero_a: assert property (@(posedge clk) disable iff (rst)
    $rose(req_r) |-> $past(ct.speed_zero))
    else $error("coil test started with shaft turning");

  hold_no_retrig_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_IDLE && !armed_r) |=> !$rose(req_r))
    else $error("coil test retriggered without trigger release");

  count_step_a: assert property (@(posedge clk) disable iff (rst)
    ($rose(req_r) && $past(count_r) != 8'hFF) |-> count_r == $past(count_r) + 8'h01)
    else $error("coil test counter did not step");

  // drive released only by a finished or skipped startup test
  drive_release_a: assert property (@(posedge clk) disable iff (rst)
    $rose(drive_ok_r) |-> ($past(finish) || $past(state_r == ST_BOOT)))
    else $error("normal drive released before startup test ended");

  // a skipped startup test releases drive next cycle
  boot_skip_a: assert property (@(posedge clk) disable iff (rst)
    boot_skip_s |=> drive_ok_r && state_r == ST_IDLE)
    else $error("skipped startup test did not release drive");
endmodule

// File: pump_misc_config_coil_test.sv
// How it works
// - Mask hides supply error at low speed
// - Three speed smoothing settings with defaults
// - Trigger write of 1 starts coil test
// - Coil tests start only at zero speed
// - Normal solenoid drive held until startup test ends or is skipped
// - Read-only saturating count of tests run
// - Too many broken valves raises error
// - Per-service limp unit count, 1 to 3
// - Limp counts stored only, no effect
`timescale 1ns/10ps
module pump_misc_config_coil_test
  import coil_cfg_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  input  wire logic                                  ce,
  // Parameter access port
  input  wire logic                                  wr_en,
  input  wire logic [coil_cfg_pkg::IDX_W-1:0]        wr_index,
  input  wire logic [coil_cfg_pkg::DATA_W-1:0]       wr_data,
  input  wire logic [coil_cfg_pkg::IDX_W-1:0]        rd_index,
  output logic      [coil_cfg_pkg::DATA_W-1:0]       rd_data,
  // Speed sensor logic
  input  wire logic                                  speed_zero,
  input  wire logic                                  speed_below_low,
  output logic      [coil_cfg_pkg::EDGE_W-1:0]       smooth_edges,
  output logic      [coil_cfg_pkg::PERIOD_W-1:0]     smooth_period,
  output logic      [coil_cfg_pkg::ANGLE_W-1:0]      smooth_angle,
  // Supply and valve monitoring
  input  wire logic                                  supply_low_raw,
  input  wire logic [3*coil_cfg_pkg::BROKEN_W-1:0]   broken_count,
  output logic                                       supply_error,
  output logic                                       valve_adapt_fail,
  // Solenoid test driver
  input  wire logic                                  coil_done,
  output logic                                       coil_req,
  output logic                                       drive_ok
);
  import coil_cfg_pkg::*;

  logic                supply_mask_r;
  logic [EDGE_W-1:0]   edge_r;
  logic [PERIOD_W-1:0] period_r;
  logic [ANGLE_W-1:0]  angle_r;
  logic                manual_r;
  logic                startup_r;
  logic [BROKEN_W-1:0] broken_lim_r [NUM_SVC];
  logic [LIMP_W-1:0]   limp_r       [NUM_SVC];
  logic [DATA_W-1:0]   rd_data_r;
  logic                supply_err_r;
  logic                valve_fail_r;
  logic [NUM_SVC-1:0]  svc_over;
  logic [DATA_W-1:0]   rd_words     [NUM_REGS];

  coil_test_if ct ();

  // Write decode
  wire wr_mask    = wr_en & (wr_index == IDX_SUPPLY_MASK);
  wire wr_edge    = wr_en & (wr_index == IDX_EDGE_COUNT);
  wire wr_period  = wr_en & (wr_index == IDX_PERIOD);
  wire wr_angle   = wr_en & (wr_index == IDX_ANGLE);
  wire wr_manual  = wr_en & (wr_index == IDX_MANUAL_TRIG);
  wire wr_startup = wr_en & (wr_index == IDX_STARTUP_EN);

  wire [EDGE_W-1:0]   edge_nxt   = (wr_data > MAX_EDGE_COUNT) ? MAX_EDGE_COUNT[EDGE_W-1:0]
                                                              : wr_data[EDGE_W-1:0];
  wire [PERIOD_W-1:0] period_nxt = (wr_data > MAX_PERIOD) ? MAX_PERIOD[PERIOD_W-1:0]
                                                          : wr_data[PERIOD_W-1:0];
  wire [ANGLE_W-1:0]  angle_nxt  = (wr_data > MAX_ANGLE) ? MAX_ANGLE[ANGLE_W-1:0]
                                                         : wr_data[ANGLE_W-1:0];
  wire [BROKEN_W-1:0] broken_nxt = (wr_data > MAX_BROKEN) ? MAX_BROKEN[BROKEN_W-1:0]
                                                          : wr_data[BROKEN_W-1:0];
  wire [LIMP_W-1:0]   limp_nxt   = (wr_data > MAX_LIMP) ? MAX_LIMP[LIMP_W-1:0]
                                 : (wr_data < MIN_LIMP) ? MIN_LIMP[LIMP_W-1:0]
                                                        : wr_data[LIMP_W-1:0];
  // Single-bit parameters take any nonzero value as 1
  wire                bit_nxt    = (wr_data != 16'h0000);

  // smoothing settings held for the speed sensor logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edge_r   <= RST_EDGE_COUNT;
      period_r <= RST_PERIOD;
      angle_r  <= RST_ANGLE;
    end else if (ce) begin
      if (wr_edge) edge_r <= edge_nxt;
      if (wr_period) period_r <= period_nxt;
      if (wr_angle) angle_r <= angle_nxt;
    end
  end

  // trigger and enable bits; the sequencer sees the trigger level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      supply_mask_r <= RST_SUPPLY_MASK;
      manual_r      <= RST_MANUAL_TRIG;
      startup_r     <= RST_STARTUP_EN;
    end else if (ce) begin
      if (wr_mask) supply_mask_r <= bit_nxt;
      if (wr_manual) manual_r <= bit_nxt;
      if (wr_startup) startup_r <= bit_nxt;
    end
  end

  // Per-service limits; limp counts are kept only for readback
  genvar s;
  generate
    for (s = 0; s < NUM_SVC; s++) begin : g_svc
      wire [IDX_W-1:0] broken_idx = IDX_BROKEN_SVC1 + IDX_W'(s);
      wire [IDX_W-1:0] limp_idx   = IDX_LIMP_SVC1 + IDX_W'(s);
      assign svc_over[s] = broken_count[s*BROKEN_W +: BROKEN_W] > broken_lim_r[s];
      assign rd_words[IDX_BROKEN_SVC1 + s] = {12'h000, broken_lim_r[s]};
      // limp counts drive nothing but readback
      assign rd_words[IDX_LIMP_SVC1 + s]   = {14'h0000, limp_r[s]};
      // broken limit and limp count storage, reset to 0 and 1
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          broken_lim_r[s] <= RST_BROKEN;
          limp_r[s]       <= RST_LIMP;
        end else if (ce) begin
          if (wr_en && wr_index == broken_idx) broken_lim_r[s] <= broken_nxt;
          if (wr_en && wr_index == limp_idx) limp_r[s] <= limp_nxt;
        end
      end
    end
  endgenerate

  // Readback words; unused bits read as zero
  assign rd_words[IDX_SUPPLY_MASK] = {15'h0000, supply_mask_r};
  assign rd_words[IDX_EDGE_COUNT]  = {9'h000, edge_r};
  assign rd_words[IDX_PERIOD]      = {1'h0, period_r};
  assign rd_words[IDX_ANGLE]       = {3'h0, angle_r};
  assign rd_words[IDX_MANUAL_TRIG] = {15'h0000, manual_r};
  assign rd_words[IDX_STARTUP_EN]  = {15'h0000, startup_r};
  // counter is read only, writes to it are dropped
  assign rd_words[IDX_RUN_COUNT]   = {8'h00, ct.run_count};

  // Indices past the map read as zero
  wire [DATA_W-1:0] rd_mux = (rd_index < NUM_REGS[IDX_W-1:0]) ? rd_words[rd_index] : 16'h0000;

  // Registered read word; frozen with ce low like every other flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_r <= 16'h0000;
    end else if (ce) begin
      rd_data_r <= rd_mux;
    end
  end

  // suppress supply error at low speed when masked
  wire supply_err_nxt = supply_low_raw & ~(supply_mask_r & speed_below_low);

  // adaptation failure when any service exceeds its limit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      supply_err_r <= 1'b0;
      valve_fail_r <= 1'b0;
    end else if (ce) begin
      supply_err_r <= supply_err_nxt;
      valve_fail_r <= |svc_over;
    end
  end

  // Sequencer link; speed and done come from logic on this clock
  assign ct.startup_en  = startup_r;
  assign ct.manual_trig = manual_r;
  assign ct.speed_zero  = speed_zero;
  assign ct.coil_done   = coil_done;

  coil_test_seq u_seq (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .ct  (ct.seq)
  );

  // Outputs, all taken from flip-flops
  assign rd_data          = rd_data_r;
  assign smooth_edges     = edge_r;
  assign smooth_period    = period_r;
  assign smooth_angle     = angle_r;
  assign supply_error     = supply_err_r;
  assign valve_adapt_fail = valve_fail_r;
  assign coil_req         = ct.coil_req;
  assign drive_ok         = ct.drive_ok;

  sequence edge_over_s;
    ce && wr_edge && wr_data > 16'h0064;
  endsequence

  sequence limp_zero_s;
    ce && wr_en && wr_index == IDX_LIMP_SVC1 && wr_data == 16'h0000;
  endsequence

  // masked low-speed supply error stays quiet
  supply_mask_a: assert property (@(posedge clk) disable iff (rst)
    (ce && supply_mask_r && speed_below_low) |=> !supply_err_r)
    else $error("supply error raised while masked at low speed");

  supply_pass_a: assert property (@(posedge clk) disable iff (rst)
    (ce && supply_low_raw && !supply_mask_r) |=> supply_err_r)
    else $error("supply error lost while unmasked");

  // edge count saturates at its maximum
  edge_clamp_a: assert property (@(posedge clk) disable iff (rst)
    edge_over_s |=> edge_r == 7'h64)
    else $error("edge count write not saturated");

  limp_floor_a: assert property (@(posedge clk) disable iff (rst)
    limp_zero_s |=> limp_r[0] == 2'h1)
    else $error("limp count accepted zero");

  // stored angle, third-service broken limit and second-service limp count stay inside their ranges
  range_hold_a: assert property (@(posedge clk) disable iff (rst)
    angle_r <= 13'h1C20 && broken_lim_r[2] <= 4'hB && limp_r[1] != 2'h0)
    else $error("stored parameter out of range");

  // overflow of any service raises the error
  valve_fail_a: assert property (@(posedge clk) disable iff (rst)
    (ce && |svc_over) |=> valve_fail_r)
    else $error("valve adaptation failure not raised");

  count_read_a: assert property (@(posedge clk) disable iff (rst)
    (ce && rd_index == IDX_RUN_COUNT) |=> rd_data_r == {8'h00, $past(ct.run_count)})
    else $error("test counter readback mismatch");

  // drive is released exactly when the startup test request drops
  drive_block_a: assert property (@(posedge clk) disable iff (rst)
    (coil_req && !drive_ok) |=> (drive_ok == !coil_req))
    else $error("drive permit and startup test request out of step");
endmodule

// File: coil_driver_model.sv
`timescale 1ns/10ps
// Solenoid driver stand-in: answers each test request after a set delay
module coil_driver_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Test handshake
  input  wire logic       coil_req,
  input  wire logic [3:0] delay,
  output logic            coil_done
);
  logic [3:0] cnt_r;

  // One-cycle answer; the count restarts only once the request drops,
  // so a request still high after the answer gets a second pulse only when the 4-bit count wraps, 16 cycles later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r     <= 4'h0;
      coil_done <= 1'b0;
    end else begin
      cnt_r     <= coil_req ? cnt_r + 4'h1 : 4'h0;
      coil_done <= coil_req && !coil_done && (cnt_r == delay);
    end
  end
endmodule

// File: tb.sv
`timescale 1ns/10ps
module tb;
  import coil_cfg_pkg::*;
  typedef struct {int kind; logic [15:0] val;} note_t;
  localparam int K_RD = 0, K_EDGE = 1, K_PER = 2, K_ANG = 3;
  localparam int K_SUP = 4, K_VLV = 5, K_REQ = 6, K_DRV = 7;
  localparam int NT = 14;
  localparam logic [3:0] T_IDX [NT] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h3, 4'h5, 4'h7,
                                        4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'h6, 4'hD};
  localparam logic [15:0] T_WR [NT] = '{16'h0005, 16'h00C8, 16'hFFFF, 16'h2000,
    16'h0123, 16'h0000, 16'h000C, 16'h0003, 16'h0005, 16'h0000, 16'h0007,
    16'h0002, 16'h0055, 16'h1234};
  localparam logic [15:0] T_EXP [NT] = '{16'h0001, 16'h0064, 16'h7FFF, 16'h1C20,
    16'h0123, 16'h0000, 16'h000B, 16'h0003, 16'h0005, 16'h0001, 16'h0003,
    16'h0002, 16'h0001, 16'h0000};
  localparam logic [15:0] DFLT [13] = '{16'h0000, 16'h000D, 16'h7FFF, 16'h1C20,
    16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0001,
    16'h0001, 16'h0001};

  logic                  clk, rst, ce, wr_en, speed_zero, speed_below_low;
  logic                  supply_low_raw, coil_done, coil_req, drive_ok;
  logic                  supply_error, valve_adapt_fail, msk;
  logic [IDX_W-1:0]      wr_index, rd_index;
  logic [DATA_W-1:0]     wr_data, rd_data;
  logic [EDGE_W-1:0]     smooth_edges;
  logic [PERIOD_W-1:0]   smooth_period;
  logic [ANGLE_W-1:0]    smooth_angle;
  logic [3*BROKEN_W-1:0] broken_count;
  logic [3:0]            delay;
  logic [31:0]           r;
  int                    n_mismatch, checks, cycles, i;
  note_t                 exp_q[$];
  note_t                 nt;
  event                  chk_ev;

  pump_misc_config_coil_test dut (.clk(clk), .rst(rst), .ce(ce), .wr_en(wr_en),
    .wr_index(wr_index), .wr_data(wr_data), .rd_index(rd_index), .rd_data(rd_data),
    .speed_zero(speed_zero), .speed_below_low(speed_below_low),
    .smooth_edges(smooth_edges), .smooth_period(smooth_period),
    .smooth_angle(smooth_angle), .supply_low_raw(supply_low_raw),
    .broken_count(broken_count), .supply_error(supply_error),
    .valve_adapt_fail(valve_adapt_fail), .coil_done(coil_done),
    .coil_req(coil_req), .drive_ok(drive_ok));

  coil_driver_model drv (.clk(clk), .rst(rst), .coil_req(coil_req), .delay(delay),
    .coil_done(coil_done));

  // Free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic final_report();
    $display("mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp_word(input logic [15:0] act, input logic [15:0] exp, input string w);
    checks++;
    if (act !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, w, act, exp);
    end
  endtask

  task automatic cmp_flag(input logic act, input logic exp, input string w);
    checks++;
    if (act !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %b expected %b", $time, w, act, exp);
    end
  endtask

  task automatic note(input int k, input logic [15:0] v);
    exp_q.push_back('{k, v});
    -> chk_ev;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [15:0] d);
    @(posedge clk);
    wr_en    <= 1'b1;
    wr_index <= idx;
    wr_data  <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read word shows one edge after the index is set
  task automatic rd(input logic [3:0] idx, input logic [15:0] e);
    @(posedge clk);
    rd_index <= idx;
    @(posedge clk);
    @(negedge clk);
    note(K_RD, e);
  endtask

  // Bounded wait for the request level, then note it
  task automatic wait_req(input logic lvl);
    int n;
    n = 0;
    while (coil_req !== lvl && n < 40) begin
      @(negedge clk);
      n++;
    end
    note(K_REQ, {15'h0, lvl});
  endtask

  // Watcher: each noted result is compared against the output it names
  always begin
    @(chk_ev);
    while (exp_q.size() > 0) begin
      nt = exp_q.pop_front();
      case (nt.kind)
        K_RD:    cmp_word(rd_data, nt.val, "read data");
        K_EDGE:  cmp_word({9'h0, smooth_edges}, nt.val, "edge count");
        K_PER:   cmp_word({1'h0, smooth_period}, nt.val, "period");
        K_ANG:   cmp_word({3'h0, smooth_angle}, nt.val, "angle");
        K_SUP:   cmp_flag(supply_error, nt.val[0], "supply error");
        K_VLV:   cmp_flag(valve_adapt_fail, nt.val[0], "valve fail");
        K_REQ:   cmp_flag(coil_req, nt.val[0], "coil request");
        default: cmp_flag(drive_ok, nt.val[0], "drive permit");
      endcase
    end
  end

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    void'($urandom(41));
    {rst, ce, speed_zero} = 3'b111;
    {wr_en, speed_below_low, supply_low_raw, msk} = 4'h0;
    {wr_index, wr_data, rd_index, broken_count} = '0;
    delay = 4'h2;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    note(K_REQ, 16'h0001);
    note(K_DRV, 16'h0000);
    wait_req(1'b0);
    note(K_DRV, 16'h0001);
    for (i = 0; i < 13; i++)
      rd(i[3:0], DFLT[i]);
    // Saturation, read-only count and unmapped index
    for (i = 0; i < NT; i++) begin
      wr(T_IDX[i], T_WR[i]);
      rd(T_IDX[i], T_EXP[i]);
    end
    note(K_EDGE, 16'h0064);
    note(K_PER, 16'h7FFF);
    note(K_ANG, 16'h0123);
    msk = 1'b1;
    // Random supply and broken-valve stimulus against the stored limits
    for (i = 0; i < 24; i++) begin
      if (i == 12) begin
        wr(4'h0, 16'h0000);
        msk = 1'b0;
      end
      r = $urandom;
      @(posedge clk);
      broken_count    <= r[11:0];
      supply_low_raw  <= r[12];
      speed_below_low <= r[13];
      @(posedge clk);
      @(negedge clk);
      note(K_SUP, {15'h0, r[12] & ~(msk & r[13])});
      note(K_VLV, {15'h0, (r[3:0] > 4'hB) | (r[7:4] > 4'h3) | (r[11:8] > 4'h5)});
    end
    // Smoothing angle goes back to its default before normal use
    wr(4'h3, 16'h1C20);
    // Manual test held off while the shaft turns, then run slowly
    delay      <= 4'h9;
    speed_zero <= 1'b0;
    wr(4'h4, 16'h0001);
    repeat (6) @(negedge clk);
    note(K_REQ, 16'h0000);
    @(posedge clk);
    speed_zero <= 1'b1;
    wait_req(1'b1);
    note(K_DRV, 16'h0001);
    wait_req(1'b0);
    rd(4'h6, 16'h0002);
    note(K_ANG, 16'h1C20);
    repeat (6) @(negedge clk);
    note(K_REQ, 16'h0000);
    wr(4'h4, 16'h0000);
    wr(4'h4, 16'h0001);
    wait_req(1'b1);
    wait_req(1'b0);
    rd(4'h6, 16'h0003);
    // Mid-run reset with the shaft turning: startup test withheld
    @(posedge clk);
    rst        <= 1'b1;
    speed_zero <= 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    note(K_REQ, 16'h0000);
    note(K_DRV, 16'h0001);
    rd(4'h6, 16'h0000);
    // Clock enable low: a write must not land
    @(posedge clk);
    ce <= 1'b0;
    wr(4'h1, 16'h0005);
    ce <= 1'b1;
    rd(4'h1, 16'h000D);
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule
